// [rtl/srxi_fifo_mem.sv]
// srxi_fifo_mem: eight-byte receive data store with registered read.
// assumes one writer and a read address held stable by the caller.
`timescale 1ns/1ps
module srxi_fifo_mem
    import srxi_pkg::*;
(
    // clock
    input  wire logic       clk,
    // write side
    input  wire logic       wr_en,
    input  wire logic [2:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // read side
    input  wire logic [2:0] rd_addr,
    output logic      [7:0] rd_data
);
    logic [7:0] mem [0:7];

    // storage, no reset needed for data
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read data lags the address by one cycle
    always_ff @(posedge clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule

// [rtl/srxi_params.svh]
// srxi_params.svh: offsets, field positions, reset values and codes of the
// receive interrupt block; the top module and the bench include this header.
// Notes on behaviour
// - sources are char-available and special condition
// - mode in control D4:D3, modifier D2
// - data read pops data and status together
// - status D0 set whenever FIFO holds data
// - pending bits set even with master enable off
// - threshold clear: request on one byte
// - threshold set: four clean bytes or special
// - reset-under-service with four left re-requests
// - threshold set: special in top four interrupts
// - threshold set: no FIFO lock on special
// - new request only while under-service clear
// - disabled mode never requests, status still valid
// - first-char mode: first byte sets pending
// - later chars silent until enable-next or special
// - first-char and special-only modes: special locks exit entry after its read
// - only error-reset command releases the lock
// - first-char and special share pending, under-service
// - vector codes 010/011 chan B, 110/111 chan A
// - all-chars mode, threshold clear: pending while exit holds data
// - special-only mode: only special chars pend
`ifndef SRXI_PARAMS_SVH
`define SRXI_PARAMS_SVH
// register byte offsets on the bus
`define SRXI_OFF_CTRL      8'h00
`define SRXI_OFF_EXTOPT    8'h04
`define SRXI_OFF_MASTER    8'h08
`define SRXI_OFF_CMD       8'h0c
`define SRXI_OFF_STATUS    8'h10
`define SRXI_OFF_RXCOND    8'h14
`define SRXI_OFF_DATA      8'h18
`define SRXI_OFF_VECTOR    8'h1c
`define SRXI_OFF_PENDING   8'h20
// field positions
`define SRXI_CTRL_MODE_HI  4
`define SRXI_CTRL_MODE_LO  3
`define SRXI_CTRL_PAR_BIT  2
`define SRXI_EXT_THR_BIT   3
`define SRXI_MIC_MIE_BIT   3
`define SRXI_MIC_CHA_BIT   4
`define SRXI_CMD_HI        5
`define SRXI_CMD_LO        3
`define SRXI_PEND_A_BIT    5
`define SRXI_PEND_B_BIT    2
// reset values
`define SRXI_RST_REG8      8'h00
// FIFO geometry and threshold
`define SRXI_DEPTH         4'h8
`define SRXI_THRESHOLD     4'h4
// vector status codes
`define SRXI_VEC_B_AVAIL   3'h2
`define SRXI_VEC_B_SPEC    3'h3
`define SRXI_VEC_A_AVAIL   3'h6
`define SRXI_VEC_A_SPEC    3'h7
`endif

// [rtl/srxi_pkg.sv]
// srxi_pkg: types of the receive interrupt block.
// assumes srxi_params.svh sits beside it in the include path.
package srxi_pkg;
    // receive interrupt mode field
    typedef enum logic [1:0] {
        SRXI_MODE_OFF   = 2'b00,
        SRXI_MODE_FIRST = 2'b01,
        SRXI_MODE_ALL   = 2'b10,
        SRXI_MODE_SPEC  = 2'b11
    } srxi_mode_type;
    // command field codes
    typedef enum logic [2:0] {
        SRXI_CMD_NULL     = 3'b000,
        SRXI_CMD_EN_NEXT  = 3'b100,
        SRXI_CMD_ERR_RST  = 3'b110,
        SRXI_CMD_RST_IUS  = 3'b111
    } srxi_cmd_type;
endpackage

// [rtl/srxi_top.sv]
// srxi_top: receive interrupt logic of one serial channel behind an APB slave.
// assumes receiver strobes bytes with status, and an acknowledge pulse input.
`timescale 1ns/1ps
`include "srxi_params.svh"
module srxi_top
    import srxi_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // receiver byte stream
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_overrun,
    input  wire logic        rx_framing,
    input  wire logic        rx_eof,
    input  wire logic        rx_parity,
    // interrupt handshake and full flag to the receiver
    input  wire logic        int_ack,
    output logic             int_req,
    output logic             rx_full
);
    logic [7:0]    ctrl;
    logic [7:0]    ext_opt;
    logic [7:0]    master;
    logic [7:0]    vec_base;
    logic [2:0]    wr_ptr;
    logic [2:0]    rd_ptr;
    logic [3:0]    count;
    logic [3:0]    st_mem [0:7];
    logic [7:0]    rd_q;
    logic          ip_q;
    logic          special_q;
    logic          int_under_service;
    logic          lock;
    logic          armed;
    logic          next_ip;
    logic          next_special;
    logic          special_top4;
    logic          exit_special;
    logic [2:0]    vec_code;
    logic [31:0]   next_rdata;
    logic          next_err;
    srxi_mode_type mode;
    srxi_cmd_type  cmd;
    logic          thr;
    logic          master_int_enable;
    logic          par_spec;
    logic          lock_en;
    logic          is_data_rd;
    logic          load_rd;
    logic          acc;
    logic          wr_acc;
    logic          rd_acc;
    logic          cmd_wr;
    logic          push;
    logic          pop;
    logic          lock_set;
    logic          err_rst;
    logic          ius_rst;
    logic          en_next;
    logic          first_sel;

    // decoded fields
    assign mode     = srxi_mode_type'(ctrl[`SRXI_CTRL_MODE_HI:`SRXI_CTRL_MODE_LO]);
    assign par_spec = ctrl[`SRXI_CTRL_PAR_BIT];
    assign thr      = ext_opt[`SRXI_EXT_THR_BIT];
    assign master_int_enable      = master[`SRXI_MIC_MIE_BIT];
    assign cmd      = srxi_cmd_type'(pwdata[`SRXI_CMD_HI:`SRXI_CMD_LO]);
    // lock only in modes where data is read blind, never with threshold on
    assign lock_en  = (mode == SRXI_MODE_FIRST || mode == SRXI_MODE_SPEC) && !thr;

    // bus phase decode; data reads take one wait state for the registered store
    assign is_data_rd = !pwrite && paddr == `SRXI_OFF_DATA;
    assign load_rd    = psel && !pready && (penable || !is_data_rd);
    assign acc        = psel && penable && pready;
    assign wr_acc     = acc && pwrite;
    assign rd_acc     = acc && !pwrite;
    assign cmd_wr     = wr_acc && paddr == `SRXI_OFF_CMD;
    assign err_rst    = cmd_wr && cmd == SRXI_CMD_ERR_RST;
    assign ius_rst    = cmd_wr && cmd == SRXI_CMD_RST_IUS;
    assign en_next    = cmd_wr && cmd == SRXI_CMD_EN_NEXT;
    assign first_sel  = wr_acc && paddr == `SRXI_OFF_CTRL
                        && pwdata[`SRXI_CTRL_MODE_HI:`SRXI_CTRL_MODE_LO] == 2'b01
                        && mode != SRXI_MODE_FIRST;

    // special condition of the exit entry and of the four exit-side entries
    always_comb begin
        logic [3:0] st;
        logic [2:0] idx;
        st           = st_mem[rd_ptr];
        idx          = 3'h0;
        exit_special = (count != 4'h0)
                       && (st[3] || st[2] || st[1] || (st[0] && par_spec));
        special_top4 = 1'b0;
        for (int i = 0; i < 4; i++) begin
            idx = rd_ptr + 3'(i);
            st  = st_mem[idx];
            if (4'(i) < count && (st[3] || st[2] || st[1] || (st[0] && par_spec))) begin
                special_top4 = 1'b1;
            end
        end
    end

    // fifo moves: push from receiver, pop on data read unless locked
    assign push     = rx_valid && count != `SRXI_DEPTH;
    assign lock_set = rd_acc && paddr == `SRXI_OFF_DATA && count != 4'h0
                      && !lock && lock_en && exit_special;
    assign pop      = (rd_acc && paddr == `SRXI_OFF_DATA && count != 4'h0
                       && !lock && !lock_set)
                      || (err_rst && lock);

    srxi_fifo_mem u_mem (
        .clk     (clk),
        .wr_en   (push),
        .wr_addr (wr_ptr),
        .wr_data (rx_data),
        .rd_addr (rd_ptr),
        .rd_data (rd_q)
    );

    // four-bit status entries travel beside the data bytes
    always_ff @(posedge clk) begin
        if (push) begin
            st_mem[wr_ptr] <= {rx_eof, rx_framing, rx_overrun, rx_parity};
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            count  <= 4'h0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 3'h1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 3'h1;
            end
            count <= count + {3'h0, push} - {3'h0, pop};
        end
    end

    // full flag shown to the receiver
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_full <= 1'b0;
        end else begin
            rx_full <= (count + {3'h0, push} - {3'h0, pop}) == `SRXI_DEPTH;
        end
    end

    // exit lock on special condition, released by error reset only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock <= 1'b0;
        end else if (lock_set) begin
            lock <= 1'b1;
        end else if (err_rst) begin
            lock <= 1'b0;
        end
    end

    // first-character arm; a re-arm in the same cycle as a pop wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed <= 1'b0;
        end else if (first_sel || en_next) begin
            armed <= 1'b1;
        end else if (pop && mode == SRXI_MODE_FIRST) begin
            armed <= 1'b0;
        end
    end

    // pending computation per mode; runs in every enabled mode for polling
    always_comb begin
        next_ip      = 1'b0;
        next_special = lock;
        case (mode)
            SRXI_MODE_OFF: begin
                next_ip = 1'b0;
            end
            SRXI_MODE_FIRST: begin
                next_ip = (armed && count != 4'h0) || lock;
            end
            SRXI_MODE_ALL: begin
                if (thr) begin
                    next_ip      = count >= `SRXI_THRESHOLD || special_top4;
                    next_special = special_top4;
                end else begin
                    next_ip      = count != 4'h0 || lock;
                    next_special = exit_special || lock;
                end
            end
            SRXI_MODE_SPEC: begin
                next_ip = lock;
            end
            default: begin
                next_ip = 1'b0;
            end
        endcase
    end

    // registered pending and kind of pending
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ip_q      <= 1'b0;
            special_q <= 1'b0;
        end else begin
            ip_q      <= next_ip;
            special_q <= next_special;
        end
    end

    // under-service: set by acknowledge, cleared by command; set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_under_service <= 1'b0;
        end else if (int_ack && int_req) begin
            int_under_service <= 1'b1;
        end else if (ius_rst) begin
            int_under_service <= 1'b0;
        end
    end

    // request line; master enable gates only the line, not the pending bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_req <= 1'b0;
        end else begin
            int_req <= ip_q && master_int_enable && !int_under_service && !(int_ack && int_req);
        end
    end

    // vector status code by channel
    always_comb begin
        if (master[`SRXI_MIC_CHA_BIT]) begin
            vec_code = special_q ? `SRXI_VEC_A_SPEC : `SRXI_VEC_A_AVAIL;
        end else begin
            vec_code = special_q ? `SRXI_VEC_B_SPEC : `SRXI_VEC_B_AVAIL;
        end
        if (!ip_q) begin
            vec_code = `SRXI_VEC_B_SPEC;
        end
    end

    // software registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl     <= `SRXI_RST_REG8;
            ext_opt  <= `SRXI_RST_REG8;
            master   <= `SRXI_RST_REG8;
            vec_base <= `SRXI_RST_REG8;
        end else if (wr_acc) begin
            case (paddr)
                `SRXI_OFF_CTRL: begin
                    ctrl <= pwdata[7:0];
                end
                `SRXI_OFF_EXTOPT: begin
                    ext_opt <= pwdata[7:0];
                end
                `SRXI_OFF_MASTER: begin
                    master <= pwdata[7:0];
                end
                `SRXI_OFF_VECTOR: begin
                    vec_base <= pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // read mux and unmapped decode
    always_comb begin
        next_rdata = 32'h0;
        next_err   = 1'b0;
        case (paddr)
            `SRXI_OFF_CTRL:    next_rdata = {24'h0, ctrl};
            `SRXI_OFF_EXTOPT:  next_rdata = {24'h0, ext_opt};
            `SRXI_OFF_MASTER:  next_rdata = {24'h0, master};
            `SRXI_OFF_CMD:     next_rdata = 32'h0;
            `SRXI_OFF_STATUS:  next_rdata = {31'h0, count != 4'h0};
            `SRXI_OFF_RXCOND:  next_rdata = {24'h0, st_mem[rd_ptr], 4'h0};
            `SRXI_OFF_DATA:    next_rdata = {24'h0, rd_q};
            `SRXI_OFF_VECTOR:  next_rdata = {24'h0, vec_base[7:4], vec_code, vec_base[0]};
            `SRXI_OFF_PENDING: next_rdata = master[`SRXI_MIC_CHA_BIT]
                                            ? {26'h0, ip_q, 5'h0}
                                            : {29'h0, ip_q, 2'h0};
            default:           next_err   = 1'b1;
        endcase
    end

    // bus answer flops; pready pulses one cycle per transfer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= load_rd;
            if (load_rd) begin
                prdata  <= pwrite ? 32'h0 : next_rdata;
                pslverr <= next_err;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_req_idle_ius: assert property (
        int_req |-> $past(ip_q) && $past(master_int_enable) && !$past(int_under_service))
        else $error("request raised while under service");
    a_off_no_pend: assert property (
        mode == SRXI_MODE_OFF |=> !ip_q)
        else $error("pending set in disabled mode");
    a_status_avail: assert property (
        psel && !penable && !pwrite && paddr == `SRXI_OFF_STATUS
        |=> prdata[0] == $past(count != 4'h0))
        else $error("char available bit wrong");
    a_pop_advance: assert property (
        pop |=> rd_ptr == $past(rd_ptr) + 3'h1)
        else $error("pop did not advance exit entry");
    a_lock_holds: assert property (
        lock && !err_rst |=> lock && rd_ptr == $past(rd_ptr))
        else $error("lock released without error reset");
    a_thr_four: assert property (
        mode == SRXI_MODE_ALL && thr && count >= `SRXI_THRESHOLD |=> ip_q)
        else $error("four bytes did not pend");
    a_mie_gate: assert property (
        !master_int_enable && !$past(master_int_enable) |-> !int_req)
        else $error("request with master enable off");
    a_vec_special: assert property (
        ip_q && special_q |-> vec_code[1:0] == 2'b11)
        else $error("special vector code wrong");
    a_thr_no_lock: assert property (
        thr && !lock |=> !lock)
        else $error("lock taken with threshold set");
    a_first_quiet: assert property (
        mode == SRXI_MODE_FIRST && !armed && !lock |=> !ip_q)
        else $error("first-char mode pended while disarmed");

    c_lock_taken: cover property (lock_set);
    c_thr_request: cover property (thr && ip_q ##1 int_req);
    c_first_req: cover property (mode == SRXI_MODE_FIRST && int_req);
    c_ack_then_rst: cover property (int_ack && int_req ##[1:20] ius_rst);
endmodule

// [verif/srxi_ack_model.sv]
// srxi_ack_model: host side of the interrupt handshake, pulses int_ack.
// assumes the bench enables it and sets the acknowledge latency in cycles.
`timescale 1ns/1ps
module srxi_ack_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control from the bench
    input  wire logic       ack_en,
    input  wire logic [3:0] ack_dly,
    // interrupt handshake
    input  wire logic       int_req,
    output logic            int_ack
);
    logic [3:0] wait_cnt;

    // answer only a raised request, promptly or after a latency
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            int_ack  <= 1'b0;
            wait_cnt <= 4'h0;
        end else begin
            int_ack <= 1'b0;
            if (ack_en && int_req && !int_ack) begin
                if (wait_cnt >= ack_dly) begin
                    int_ack  <= 1'b1;
                    wait_cnt <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end else begin
                wait_cnt <= 4'h0;
            end
        end
    end
endmodule

// [verif/tb_srxi_top.sv]
// tb_srxi_top: self-checking bench, apb host tasks plus a byte pusher.
// assumes srxi_top with its built-in assertions and the ack model.
`timescale 1ns/1ps
`include "srxi_params.svh"
module tb_srxi_top
    import srxi_pkg::*;
;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, perr;
    logic        rx_valid, rx_overrun, rx_framing, rx_eof, rx_parity;
    logic        int_ack, int_req, rx_full, ack_en;
    logic [7:0]  paddr, rx_data;
    logic [3:0]  ack_dly;
    logic [31:0] pwdata, prdata, rd;
    int          fails, checks;

    srxi_top u_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_overrun(rx_overrun), .rx_framing(rx_framing), .rx_eof(rx_eof),
        .rx_parity(rx_parity), .int_ack(int_ack), .int_req(int_req), .rx_full(rx_full)
    );
    srxi_ack_model u_host (
        .clk(clk), .rst(rst), .ack_en(ack_en), .ack_dly(ack_dly),
        .int_req(int_req), .int_ack(int_ack)
    );

    // 40 mhz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; pready is read right after each rising edge, before the
    // slave's flops update, so it is the value sampled at that edge; no cycle
    // limit here, a hang is left to the watchdog
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd      = prdata;
        perr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    // st holds eof, framing, overrun, parity in that order
    task automatic push(input logic [7:0] d, input logic [3:0] st);
        rx_valid <= 1'b1;
        rx_data  <= d;
        {rx_eof, rx_framing, rx_overrun, rx_parity} <= st;
        @(posedge clk);
        rx_valid <= 1'b0;
        @(posedge clk);
    endtask

    // reports whether int_req was seen high in the window
    task automatic int_seen(input logic exp, input int cyc);
        logic got;
        got = 1'b0;
        repeat (cyc) begin
            @(negedge clk);
            if (int_req === 1'b1) got = 1'b1;
        end
        @(posedge clk);
        check("int_req", {31'h0, got}, {31'h0, exp});
    endtask

    task automatic reset_dut(input int cyc);
        rst <= 1'b1;
        repeat (cyc) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic [31:0] ctl(srxi_mode_type m, logic p);
        return {27'h0, m, p, 2'h0};
    endfunction

    function automatic logic [31:0] cmdw(srxi_cmd_type c);
        return {26'h0, c, 3'h0};
    endfunction

    function automatic logic [31:0] vec(logic [2:0] code);
        return {28'h0, code, 1'b0};
    endfunction

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, rx_valid, ack_en} = 5'h0;
        {rx_eof, rx_framing, rx_overrun, rx_parity} = 4'h0;
        paddr = 8'h00;
        rx_data = 8'h00;
        pwdata = 32'h0;
        ack_dly = 4'h0;
        fails = 0;
        checks = 0;
        reset_dut(20);
        // polling with interrupts off; extension threshold left zero
        rdchk("ctrl", `SRXI_OFF_CTRL, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check("pslverr", {31'h0, perr}, 32'h1);
        wr(`SRXI_OFF_MASTER, 32'h8);
        push(8'ha5, 4'h6);
        push(8'h5a, 4'h0);
        rdchk("status", `SRXI_OFF_STATUS, 32'h1);
        rdchk("rxcond", `SRXI_OFF_RXCOND, 32'h60);
        int_seen(1'b0, 8);
        rdchk("data", `SRXI_OFF_DATA, 32'ha5);
        rdchk("rxcond", `SRXI_OFF_RXCOND, 32'h0);
        for (int i = 0; i < 7; i++) push(8'h10 + 8'(i), 4'h0);
        check("rx_full", {31'h0, rx_full}, 32'h1);
        push(8'hee, 4'h0);
        rdchk("data", `SRXI_OFF_DATA, 32'h5a);
        for (int i = 0; i < 7; i++) rdchk("data", `SRXI_OFF_DATA, 32'h10 + i);
        rdchk("status", `SRXI_OFF_STATUS, 32'h0);
        $display("test polling done");
        // channel a pending without master enable
        reset_dut(2);
        wr(`SRXI_OFF_MASTER, 32'h10);
        wr(`SRXI_OFF_CTRL, ctl(SRXI_MODE_ALL, 1'b0));
        push(8'h01, 4'h0);
        int_seen(1'b0, 8);
        rdchk("pending", `SRXI_OFF_PENDING, 32'h20);
        rdchk("vector", `SRXI_OFF_VECTOR, vec(3'h6));
        rdchk("data", `SRXI_OFF_DATA, 32'h01);
        rdchk("pending", `SRXI_OFF_PENDING, 32'h0);
        push(8'h02, 4'h8);
        rdchk("vector", `SRXI_OFF_VECTOR, vec(3'h7));
        rdchk("data", `SRXI_OFF_DATA, 32'h02);
        rdchk("status", `SRXI_OFF_STATUS, 32'h0);
        $display("test pending done");
        // request, slow acknowledge, under-service blocking
        reset_dut(2);
        ack_en  <= 1'b1;
        ack_dly <= 4'h3;
        wr(`SRXI_OFF_MASTER, 32'h8);
        wr(`SRXI_OFF_CTRL, ctl(SRXI_MODE_ALL, 1'b0));
        push(8'h11, 4'h0);
        int_seen(1'b1, 10);
        rdchk("vector", `SRXI_OFF_VECTOR, vec(3'h2));
        push(8'h12, 4'h0);
        int_seen(1'b0, 10);
        wr(`SRXI_OFF_CMD, cmdw(SRXI_CMD_RST_IUS));
        int_seen(1'b1, 10);
        $display("test service done");
        // four byte threshold, prompt acknowledge
        reset_dut(2);
        ack_dly <= 4'h0;
        wr(`SRXI_OFF_MASTER, 32'h8);
        wr(`SRXI_OFF_EXTOPT, 32'h8);
        wr(`SRXI_OFF_CTRL, ctl(SRXI_MODE_ALL, 1'b0));
        for (int i = 0; i < 3; i++) push(8'h20 + 8'(i), 4'h0);
        int_seen(1'b0, 8);
        rdchk("status", `SRXI_OFF_STATUS, 32'h1);
        push(8'h23, 4'h0);
        int_seen(1'b1, 8);
        push(8'h24, 4'h0);
        wr(`SRXI_OFF_CMD, cmdw(SRXI_CMD_RST_IUS));
        int_seen(1'b1, 8);
        rdchk("data", `SRXI_OFF_DATA, 32'h20);
        rdchk("data", `SRXI_OFF_DATA, 32'h21);
        wr(`SRXI_OFF_CMD, cmdw(SRXI_CMD_RST_IUS));
        int_seen(1'b0, 8);
        // special in the top four does not wait for the exit
        reset_dut(2);
        ack_en <= 1'b0;
        wr(`SRXI_OFF_MASTER, 32'h8);
        wr(`SRXI_OFF_EXTOPT, 32'h8);
        wr(`SRXI_OFF_CTRL, ctl(SRXI_MODE_ALL, 1'b0));
        push(8'h30, 4'h0);
        push(8'h31, 4'h4);
        int_seen(1'b1, 8);
        rdchk("vector", `SRXI_OFF_VECTOR, vec(3'h3));
        rdchk("data", `SRXI_OFF_DATA, 32'h30);
        rdchk("rxcond", `SRXI_OFF_RXCOND, 32'h40);
        rdchk("data", `SRXI_OFF_DATA, 32'h31);
        rdchk("status", `SRXI_OFF_STATUS, 32'h0);
        $display("test threshold done");
        // first character mode, re-arm, lock and error reset
        reset_dut(2);
        ack_en <= 1'b1;
        wr(`SRXI_OFF_MASTER, 32'h8);
        wr(`SRXI_OFF_CTRL, ctl(SRXI_MODE_FIRST, 1'b0));
        push(8'h40, 4'h0);
        int_seen(1'b1, 10);
        rdchk("pending", `SRXI_OFF_PENDING, 32'h4);
        rdchk("data", `SRXI_OFF_DATA, 32'h40);
        rdchk("pending", `SRXI_OFF_PENDING, 32'h0);
        wr(`SRXI_OFF_CMD, cmdw(SRXI_CMD_RST_IUS));
        push(8'h41, 4'h0);
        int_seen(1'b0, 10);
        rdchk("data", `SRXI_OFF_DATA, 32'h41);
        wr(`SRXI_OFF_CMD, cmdw(SRXI_CMD_EN_NEXT));
        push(8'h42, 4'h0);
        int_seen(1'b1, 10);
        rdchk("data", `SRXI_OFF_DATA, 32'h42);
        wr(`SRXI_OFF_CMD, cmdw(SRXI_CMD_RST_IUS));
        ack_en <= 1'b0;
        push(8'h43, 4'h8);
        rdchk("data", `SRXI_OFF_DATA, 32'h43);
        int_seen(1'b1, 8);
        rdchk("rxcond", `SRXI_OFF_RXCOND, 32'h80);
        rdchk("vector", `SRXI_OFF_VECTOR, vec(3'h3));
        rdchk("data", `SRXI_OFF_DATA, 32'h43);
        wr(`SRXI_OFF_CMD, cmdw(SRXI_CMD_RST_IUS));
        rdchk("status", `SRXI_OFF_STATUS, 32'h1);
        wr(`SRXI_OFF_CMD, cmdw(SRXI_CMD_ERR_RST));
        rdchk("status", `SRXI_OFF_STATUS, 32'h0);
        wr(`SRXI_OFF_CMD, cmdw(SRXI_CMD_EN_NEXT));
        $display("test first char done");
        // special-only mode, parity as special by the modifier bit
        reset_dut(2);
        wr(`SRXI_OFF_MASTER, 32'h8);
        wr(`SRXI_OFF_CTRL, ctl(SRXI_MODE_SPEC, 1'b0));
        push(8'h50, 4'h1);
        int_seen(1'b0, 8);
        rdchk("pending", `SRXI_OFF_PENDING, 32'h0);
        rdchk("data", `SRXI_OFF_DATA, 32'h50);
        wr(`SRXI_OFF_CTRL, ctl(SRXI_MODE_SPEC, 1'b1));
        push(8'h51, 4'h1);
        int_seen(1'b0, 6);
        rdchk("data", `SRXI_OFF_DATA, 32'h51);
        int_seen(1'b1, 8);
        wr(`SRXI_OFF_CMD, cmdw(SRXI_CMD_ERR_RST));
        rdchk("status", `SRXI_OFF_STATUS, 32'h0);
        $display("test special only done");
        final_report();
    end
endmodule
